/* File: shared/uif_regs.svh */
// register offsets, field positions, codes and reset values of the uart interrupt/fifo block
// assumes a 3-bit register address and 8-bit data on a plain strobe port
`ifndef UIF_REGS_SVH
`define UIF_REGS_SVH
`define UIF_OFS_DATA 3'h0
`define UIF_OFS_MASK 3'h1
`define UIF_OFS_SRC 3'h2
`define UIF_OFS_EFR 3'h3
`define UIF_OFS_LSR 3'h5
`define UIF_OFS_MSR 3'h6
`define UIF_EFR_ENH 4
`define UIF_EFR_ARTS 6
`define UIF_EFR_ACTS 7
`define UIF_MASK_RTS 6
`define UIF_MASK_CTS 7
`define UIF_CODE_LSR 6'h06
`define UIF_CODE_TOUT 6'h0c
`define UIF_CODE_RX_DMA_REQUEST_PIN 6'h04
`define UIF_CODE_TX_DMA_REQUEST_PIN 6'h02
`define UIF_CODE_MSR 6'h00
`define UIF_CODE_XOFF 6'h10
`define UIF_CODE_FLOW 6'h20
`define UIF_CODE_NONE 6'h01
`define UIF_TRIG_0 5'h01
`define UIF_TRIG_1 5'h04
`define UIF_TRIG_2 5'h08
`define UIF_TRIG_3 5'h0e
`define UIF_FIFO_DEPTH 5'h10
`define UIF_TOUT_CHARS 8'h04
`define UIF_TOUT_BITS 8'h0c
`define UIF_RST_MASK 8'h00
`define UIF_RST_EFR 8'h00
`define UIF_RST_TRIG 2'h0
`endif

/* File: shared/uif_pkg.sv */
// types of the uart interrupt/fifo block
// assumes uif_regs.svh for the numeric constants
package uif_pkg;
  typedef enum logic [7:0] {
    UIF_SRC_NONE = 8'h01,
    UIF_SRC_LSR = 8'h02,
    UIF_SRC_TOUT = 8'h04,
    UIF_SRC_RX_DMA_REQUEST_PIN = 8'h08,
    UIF_SRC_TX_DMA_REQUEST_PIN = 8'h10,
    UIF_SRC_MSR = 8'h20,
    UIF_SRC_XOFF = 8'h40,
    UIF_SRC_FLOW = 8'h80
  } uif_src_t;
  typedef logic [1:0] uif_trig_t;
endpackage

/* File: logic/uif_ctrl.sv */
// interrupt prioritisation and fifo control for one uart channel
// assumes data fifos, receiver, transmitter and bit timing live outside; all inputs synchronous
// Function
// RULE_01 - rts rising edge interrupts when enabled
// RULE_02 - cts rising edge interrupts when enabled
// RULE_03 - mask bits 7:6 need enhanced bit 4
// RULE_04 - source read returns highest pending code
// RULE_05 - levels 1-3 codes 06, 0c, 04
// RULE_06 - levels 4-6 codes 02, 00, 10
// RULE_07 - level 7 code 20, idle 01
// RULE_08 - line status errors interrupt, cleared by read
// RULE_09 - timeout after four chars plus twelve bits
// RULE_10 - rx ready while fill at trigger
// RULE_11 - tx ready set at trigger/empty, cleared
// RULE_12 - modem deltas interrupt, cleared by read
// RULE_13 - xoff/special set, cleared per case
// RULE_14 - flow interrupts cleared by modem read
// RULE_15 - bit 0 low when pending
// RULE_16 - bits 4,5 only with enhanced bit
// RULE_17 - bits 7:6 show fifo enable
// RULE_18 - fifo enable gates other setup bits
// RULE_19 - pointer resets self-clear, need enable
// RULE_20 - setup bit 3 selects dma mode
// RULE_21 - tx trigger 1/4/8/14, enhanced only
// RULE_22 - rx trigger 1/4/8/14, default 1
// RULE_23 - irq while any enabled source pends
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "uif_regs.svh"
module uif_ctrl (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [4:0] rx_fill_i,
  input wire logic [4:0] tx_fill_i,
  input wire logic [3:0] line_err_i,
  input wire logic [3:0] modem_delta_i,
  input wire logic [3:0] modem_lines_i,
  input wire logic xoff_det_i,
  input wire logic xon_det_i,
  input wire logic special_det_i,
  input wire logic rx_char_i,
  input wire logic bit_tick_i,
  input wire logic [3:0] char_bits_i,
  input wire logic cts_i,
  input wire logic rts_i,
  output logic irq_o,
  output logic rx_pop_o,
  output logic tx_push_o,
  output logic [7:0] tx_data_o,
  output logic rx_ptr_reset_o,
  output logic tx_ptr_reset_o,
  output logic fifo_en_o,
  output logic rx_dma_request_pin_n_o,
  output logic tx_dma_request_pin_n_o
);
  function automatic logic [4:0] trig_level(input uif_pkg::uif_trig_t code);
    case (code)
      2'h0: trig_level = `UIF_TRIG_0;
      2'h1: trig_level = `UIF_TRIG_1;
      2'h2: trig_level = `UIF_TRIG_2;
      default: trig_level = `UIF_TRIG_3;
    endcase
  endfunction

  logic [7:0] interrupt_mask_reg;
  logic [7:0] enhanced_feature_reg;
  logic fifo_en_reg;
  logic dma_mode_reg;
  uif_pkg::uif_trig_t rx_trig_reg;
  uif_pkg::uif_trig_t tx_trig_reg;
  logic [3:0] line_stat_reg;
  logic [3:0] modem_stat_reg;
  logic tout_reg;
  logic tx_int_reg;
  logic tx_reached_reg;
  logic [4:0] tx_fill_reg;
  logic xoff_reg;
  logic special_reg;
  logic flow_reg;
  logic cts_reg;
  logic rts_reg;
  logic [7:0] tout_cnt_reg;
  uif_pkg::uif_src_t cur_src;
  logic [5:0] cur_code;
  logic enh;
  logic wr_data;
  logic wr_setup;
  logic rd_data;
  logic rd_src;
  logic rd_lsr;
  logic rd_msr;
  logic rx_ready;
  logic [4:0] rx_level;
  logic [4:0] tx_level;
  logic [7:0] tout_limit;
  logic tx_set;
  logic cts_rise;
  logic rts_rise;

  assign enh = enhanced_feature_reg[`UIF_EFR_ENH];
  assign wr_data = wr_i && addr_i == `UIF_OFS_DATA;
  assign wr_setup = wr_i && addr_i == `UIF_OFS_SRC;
  assign rd_data = rd_i && addr_i == `UIF_OFS_DATA;
  assign rd_src = rd_i && addr_i == `UIF_OFS_SRC;
  assign rd_lsr = rd_i && addr_i == `UIF_OFS_LSR;
  assign rd_msr = rd_i && addr_i == `UIF_OFS_MSR;
  assign rx_level = trig_level(rx_trig_reg);
  assign tx_level = trig_level(tx_trig_reg);
  // non-fifo mode behaves as a one-deep fifo with trigger one
  assign rx_ready = fifo_en_reg ? (rx_fill_i >= rx_level) : (rx_fill_i != 5'h00); // see RULE_10
  assign tout_limit = (8'(char_bits_i) << 2) + `UIF_TOUT_BITS; // see RULE_09

  // edges of the flow lines, only counted while auto flow control runs
  assign cts_rise = cts_i && !cts_reg && enhanced_feature_reg[`UIF_EFR_ACTS];
  assign rts_rise = rts_i && !rts_reg && enhanced_feature_reg[`UIF_EFR_ARTS];

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cts_reg <= 1'b0;
      rts_reg <= 1'b0;
      tx_fill_reg <= 5'h00;
    end else begin
      cts_reg <= cts_i;
      rts_reg <= rts_i;
      tx_fill_reg <= tx_fill_i;
    end
  end

  // software registers
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      interrupt_mask_reg <= `UIF_RST_MASK;
      enhanced_feature_reg <= `UIF_RST_EFR;
    end else begin
      if (wr_i && addr_i == `UIF_OFS_MASK) begin
        interrupt_mask_reg <= wdata_i;
      end
      if (wr_i && addr_i == `UIF_OFS_EFR) begin
        enhanced_feature_reg <= wdata_i;
      end
    end
  end

  // fifo setup is write-only; bit 0 low disables and drops the rest of the byte
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      fifo_en_reg <= 1'b0;
      dma_mode_reg <= 1'b0;
      rx_trig_reg <= `UIF_RST_TRIG;
      tx_trig_reg <= `UIF_RST_TRIG;
      rx_ptr_reset_o <= 1'b0;
      tx_ptr_reset_o <= 1'b0;
    end else begin
      rx_ptr_reset_o <= 1'b0;
      tx_ptr_reset_o <= 1'b0;
      if (wr_setup) begin
        fifo_en_reg <= wdata_i[0]; // see RULE_18
        if (wdata_i[0]) begin
          rx_ptr_reset_o <= wdata_i[1]; // see RULE_19
          tx_ptr_reset_o <= wdata_i[2]; // see RULE_19
          dma_mode_reg <= wdata_i[3]; // see RULE_20
          rx_trig_reg <= wdata_i[7:6]; // see RULE_22
          if (enh) begin
            tx_trig_reg <= wdata_i[5:4]; // see RULE_21
          end
        end
      end
    end
  end

  // sticky line status and modem deltas; a new event beats the clearing read
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      line_stat_reg <= 4'h0;
      modem_stat_reg <= 4'h0;
    end else begin
      line_stat_reg <= (rd_lsr ? 4'h0 : line_stat_reg) | line_err_i; // see RULE_08
      modem_stat_reg <= (rd_msr ? 4'h0 : modem_stat_reg) | modem_delta_i; // see RULE_12
    end
  end

  // receive timeout: restarts on every character or data read, only armed with data waiting
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      tout_cnt_reg <= 8'h00;
      tout_reg <= 1'b0;
    end else begin
      if (rx_char_i || rd_data || rx_fill_i == 5'h00) begin
        tout_cnt_reg <= 8'h00;
      end else if (bit_tick_i && tout_cnt_reg != tout_limit) begin
        tout_cnt_reg <= tout_cnt_reg + 8'h01;
      end
      // the timer parks at its limit, so the clearing read must gate the set or it never clears
      if (rx_fill_i != 5'h00 && tout_cnt_reg == tout_limit && !rd_data) begin
        tout_reg <= 1'b1; // see RULE_09
      end else if (rd_data) begin
        tout_reg <= 1'b0;
      end
    end
  end

  // tx ready: falling below trigger, or empty after a reload that never reached it
  assign tx_set = (tx_fill_i < tx_level && tx_fill_reg >= tx_level) ||
                  (tx_fill_i == 5'h00 && tx_fill_reg != 5'h00 && !tx_reached_reg) ||
                  (wr_i && addr_i == `UIF_OFS_MASK && wdata_i[1] &&
                   !interrupt_mask_reg[1] && tx_fill_i == 5'h00);
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      tx_int_reg <= 1'b0;
      tx_reached_reg <= 1'b0;
    end else begin
      if (tx_set) begin
        tx_int_reg <= 1'b1; // see RULE_11
      end else if (wr_data || (rd_src && cur_src == uif_pkg::UIF_SRC_TX_DMA_REQUEST_PIN)) begin
        tx_int_reg <= 1'b0; // see RULE_11
      end
      if (tx_fill_i >= tx_level) begin
        tx_reached_reg <= 1'b1; // see RULE_21
      end else if (tx_fill_i == 5'h00) begin
        tx_reached_reg <= 1'b0;
      end
    end
  end

  // xoff, special character and flow-line events
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      xoff_reg <= 1'b0;
      special_reg <= 1'b0;
      flow_reg <= 1'b0;
    end else begin
      if (xoff_det_i) begin
        xoff_reg <= 1'b1; // see RULE_13
      end else if (xon_det_i || (rd_src && cur_src == uif_pkg::UIF_SRC_XOFF)) begin
        xoff_reg <= 1'b0;
      end
      if (special_det_i) begin
        special_reg <= 1'b1; // see RULE_13
      end else if (rx_char_i || (rd_src && cur_src == uif_pkg::UIF_SRC_XOFF)) begin
        special_reg <= 1'b0;
      end
      if (enh && ((cts_rise && interrupt_mask_reg[`UIF_MASK_CTS]) ||
                  (rts_rise && interrupt_mask_reg[`UIF_MASK_RTS]))) begin
        flow_reg <= 1'b1; // see RULE_01 see RULE_02 see RULE_03 see RULE_14
      end else if (rd_msr) begin
        flow_reg <= 1'b0; // see RULE_14
      end
    end
  end

  // priority encoder over enabled sources; lower ones wait until the top one is serviced
  always_comb begin
    if (interrupt_mask_reg[2] && line_stat_reg != 4'h0) begin
      cur_src = uif_pkg::UIF_SRC_LSR; // see RULE_04
    end else if (interrupt_mask_reg[0] && tout_reg) begin
      cur_src = uif_pkg::UIF_SRC_TOUT;
    end else if (interrupt_mask_reg[0] && rx_ready) begin
      cur_src = uif_pkg::UIF_SRC_RX_DMA_REQUEST_PIN;
    end else if (interrupt_mask_reg[1] && tx_int_reg) begin
      cur_src = uif_pkg::UIF_SRC_TX_DMA_REQUEST_PIN;
    end else if (interrupt_mask_reg[3] && modem_stat_reg != 4'h0) begin
      cur_src = uif_pkg::UIF_SRC_MSR;
    end else if (enh && interrupt_mask_reg[5] && (xoff_reg || special_reg)) begin
      cur_src = uif_pkg::UIF_SRC_XOFF; // see RULE_16
    end else if (enh && flow_reg) begin
      cur_src = uif_pkg::UIF_SRC_FLOW; // see RULE_16
    end else begin
      cur_src = uif_pkg::UIF_SRC_NONE;
    end
  end

  always_comb begin
    case (cur_src)
      uif_pkg::UIF_SRC_LSR: cur_code = `UIF_CODE_LSR; // see RULE_05
      uif_pkg::UIF_SRC_TOUT: cur_code = `UIF_CODE_TOUT; // see RULE_05
      uif_pkg::UIF_SRC_RX_DMA_REQUEST_PIN: cur_code = `UIF_CODE_RX_DMA_REQUEST_PIN; // see RULE_05
      uif_pkg::UIF_SRC_TX_DMA_REQUEST_PIN: cur_code = `UIF_CODE_TX_DMA_REQUEST_PIN; // see RULE_06
      uif_pkg::UIF_SRC_MSR: cur_code = `UIF_CODE_MSR; // see RULE_06
      uif_pkg::UIF_SRC_XOFF: cur_code = `UIF_CODE_XOFF; // see RULE_06
      uif_pkg::UIF_SRC_FLOW: cur_code = `UIF_CODE_FLOW; // see RULE_07
      default: cur_code = `UIF_CODE_NONE; // see RULE_07 see RULE_15
    endcase
  end

  // read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `UIF_OFS_MASK: rdata_o <= interrupt_mask_reg;
        `UIF_OFS_SRC: rdata_o <= {{2{fifo_en_reg}}, cur_code}; // see RULE_17
        `UIF_OFS_EFR: rdata_o <= enhanced_feature_reg;
        `UIF_OFS_LSR: rdata_o <= {3'h0, line_stat_reg, rx_fill_i != 5'h00};
        `UIF_OFS_MSR: rdata_o <= {modem_lines_i, modem_stat_reg};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // data strobes toward the external fifos, and the interrupt line
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rx_pop_o <= 1'b0;
      tx_push_o <= 1'b0;
      tx_data_o <= 8'h00;
      irq_o <= 1'b0;
      fifo_en_o <= 1'b0;
    end else begin
      rx_pop_o <= rd_data;
      tx_push_o <= wr_data;
      if (wr_data) begin
        tx_data_o <= wdata_i;
      end
      irq_o <= cur_src != uif_pkg::UIF_SRC_NONE; // see RULE_23
      fifo_en_o <= fifo_en_reg;
    end
  end

  // dma pins: single-transfer style in normal mode, block style in dma mode
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rx_dma_request_pin_n_o <= 1'b1;
      tx_dma_request_pin_n_o <= 1'b1;
    end else if (dma_mode_reg && fifo_en_reg) begin
      rx_dma_request_pin_n_o <= !(rx_ready || tout_reg); // see RULE_20
      tx_dma_request_pin_n_o <= tx_fill_i == `UIF_FIFO_DEPTH; // see RULE_20
    end else begin
      rx_dma_request_pin_n_o <= rx_fill_i == 5'h00;
      tx_dma_request_pin_n_o <= tx_fill_i != 5'h00;
    end
  end

  chk_src_idle: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RULE_15
    rd_src && cur_src == uif_pkg::UIF_SRC_NONE |=> rdata_o[5:0] == `UIF_CODE_NONE)
    else $error("idle source code wrong");
  chk_lsr_first: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RULE_04
    rd_src && interrupt_mask_reg[2] && line_stat_reg != 4'h0 |=> rdata_o[5:0] == `UIF_CODE_LSR)
    else $error("line status not top priority");
  chk_fifo_bits: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RULE_17
    rd_src |=> rdata_o[7:6] == {2{$past(fifo_en_reg)}})
    else $error("fifo enable bits wrong");
  chk_setup_gate: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RULE_18
    wr_setup && !wdata_i[0] |=> !fifo_en_reg && $stable(rx_trig_reg) && !rx_ptr_reset_o)
    else $error("setup write without enable took effect");
  chk_reset_pulse: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RULE_19
    rx_ptr_reset_o && !wr_setup |=> !rx_ptr_reset_o)
    else $error("pointer reset not self clearing");
  chk_tx_trig: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RULE_21
    wr_setup && !enh |=> $stable(tx_trig_reg))
    else $error("tx trigger changed without enhanced bit");
  chk_lsr_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RULE_08
    rd_lsr && line_err_i == 4'h0 |=> line_stat_reg == 4'h0)
    else $error("line status not cleared by read");
  chk_flow_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RULE_14
    rd_msr && !cts_rise && !rts_rise |=> !flow_reg)
    else $error("flow interrupt not cleared by modem read");
  chk_cts_edge: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RULE_02
    enh && interrupt_mask_reg[7] && cts_rise |=> flow_reg)
    else $error("cts edge lost");
  chk_irq_line: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RULE_23
    cur_src != uif_pkg::UIF_SRC_NONE |=> irq_o)
    else $error("irq not raised");
  chk_tx_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RULE_11
    wr_data && !tx_set |=> !tx_int_reg)
    else $error("tx ready not cleared by data write");
  chk_tout_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RULE_09
    rd_data |=> !tout_reg)
    else $error("timeout not cleared by data read");
endmodule

/* File: tb/uif_env_model.sv */
// fill counters standing in for the uart data fifos around the control block
// assumes one clock and one-cycle pulses from the control block
`timescale 1ns/100ps
module uif_env_model (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic rx_char_i,
  input wire logic rx_pop_i,
  input wire logic tx_push_i,
  input wire logic tx_drain_i,
  input wire logic rx_ptr_reset_i,
  input wire logic tx_ptr_reset_i,
  output logic [4:0] rx_fill_o,
  output logic [4:0] tx_fill_o
);
  // pointer reset drops the count only; shift registers live elsewhere
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || rx_ptr_reset_i) begin
      rx_fill_o <= 5'h00;
    end else if (rx_char_i && rx_fill_o != 5'h10) begin
      rx_fill_o <= rx_fill_o + 5'h01;
    end else if (rx_pop_i && rx_fill_o != 5'h00) begin
      rx_fill_o <= rx_fill_o - 5'h01;
    end
  end
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || tx_ptr_reset_i) begin
      tx_fill_o <= 5'h00;
    end else if (tx_push_i && tx_fill_o != 5'h10) begin
      tx_fill_o <= tx_fill_o + 5'h01;
    end else if (tx_drain_i && tx_fill_o != 5'h00) begin
      tx_fill_o <= tx_fill_o - 5'h01;
    end
  end
endmodule

/* File: tb/uif_ctrl_tb_top.sv */
// self-checking bench of the uart interrupt/fifo control block
// assumes uif_regs.svh offsets and the fill model in uif_env_model.sv
`timescale 1ns/100ps
`include "uif_regs.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module uif_ctrl_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] line_err = 4'h0;
  logic [3:0] delta = 4'h0;
  logic xoff = 1'b0;
  logic xon = 1'b0;
  logic special = 1'b0;
  logic rx_char = 1'b0;
  logic tick = 1'b0;
  logic cts = 1'b0;
  logic rts = 1'b0;
  logic drain = 1'b0;
  logic [7:0] rdata, tx_data, rd_val;
  logic irq, rx_pop, tx_push, rx_rst, tx_rst, fifo_en, rx_dma_n, tx_dma_n;
  logic [4:0] rx_fill, tx_fill;
  logic [31:0] seed = 32'ha8403a21;
  int mismatches = 0;
  int comparisons = 0;
  int rx_rst_cnt = 0;
  int tx_rst_cnt = 0;

  initial forever #2 clk = ~clk;

  uif_ctrl DUT (.clock_i(clk), .reset_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rx_fill_i(rx_fill), .tx_fill_i(tx_fill),
    .line_err_i(line_err), .modem_delta_i(delta), .modem_lines_i(4'h0),
    .xoff_det_i(xoff), .xon_det_i(xon), .special_det_i(special), .rx_char_i(rx_char),
    .bit_tick_i(tick), .char_bits_i(4'h8), .cts_i(cts), .rts_i(rts), .irq_o(irq),
    .rx_pop_o(rx_pop), .tx_push_o(tx_push), .tx_data_o(tx_data),
    .rx_ptr_reset_o(rx_rst), .tx_ptr_reset_o(tx_rst), .fifo_en_o(fifo_en),
    .rx_dma_request_pin_n_o(rx_dma_n), .tx_dma_request_pin_n_o(tx_dma_n));
  uif_env_model ENV (.clock_i(clk), .reset_n_i(rst_n), .rx_char_i(rx_char),
    .rx_pop_i(rx_pop), .tx_push_i(tx_push), .tx_drain_i(drain),
    .rx_ptr_reset_i(rx_rst), .tx_ptr_reset_i(tx_rst), .rx_fill_o(rx_fill),
    .tx_fill_o(tx_fill));

  always @(posedge clk) begin
    if (rx_rst === 1'b1) rx_rst_cnt++;
    if (tx_rst === 1'b1) tx_rst_cnt++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [4:0] trig(input logic [1:0] c);
    return c == 2'h0 ? 5'h01 : c == 2'h1 ? 5'h04 : c == 2'h2 ? 5'h08 : 5'h0e;
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rd_val = rdata;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    rreg(a);
    `CHK("rdata", e, rd_val)
  endtask
  task automatic ev(input int k);
    @(posedge clk);
    case (k)
      0: line_err <= 4'h1;
      1: delta <= 4'h1;
      2: xoff <= 1'b1;
      3: xon <= 1'b1;
      4: rx_char <= 1'b1;
      5: special <= 1'b1;
      default: drain <= 1'b1;
    endcase
    @(posedge clk);
    {line_err, delta, xoff, xon, rx_char, special, drain} <= '0;
  endtask
  task automatic line_up(input logic use_rts);
    @(posedge clk);
    rts <= use_rts;
    cts <= !use_rts;
    idle(3);
    rts <= 1'b0;
    cts <= 1'b0;
  endtask
  task automatic final_report;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    idle(20000);
    mismatches++;
    final_report();
  end

  initial begin
    idle(8);
    rst_n <= 1'b1;
    rchk(`UIF_OFS_SRC, 8'h01);
    rchk(`UIF_OFS_MASK, 8'h00);
    wreg(`UIF_OFS_SRC, 8'h01);
    ev(4);
    ev(0);
    ev(1);
    wreg(`UIF_OFS_MASK, 8'h0f);
    idle(2);
    `CHK("irq", 1'b1, irq)
    rchk(`UIF_OFS_SRC, 8'hc6);
    rreg(`UIF_OFS_LSR);
    rchk(`UIF_OFS_SRC, 8'hc4);
    rreg(`UIF_OFS_DATA);
    idle(3);
    rchk(`UIF_OFS_SRC, 8'hc2);
    rchk(`UIF_OFS_SRC, 8'hc0);
    rreg(`UIF_OFS_MSR);
    rchk(`UIF_OFS_SRC, 8'hc1);
    `CHK("irq", 1'b0, irq)
    wreg(`UIF_OFS_MASK, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wreg(`UIF_OFS_SRC, {c[1:0], 6'h03});
      idle(2);
      for (int i = 1; i < trig(c[1:0]); i++) ev(4);
      rchk(`UIF_OFS_SRC, 8'hc1);
      ev(4);
      rchk(`UIF_OFS_SRC, 8'hc4);
    end
    wreg(`UIF_OFS_SRC, 8'h43);
    idle(2);
    ev(4);
    idle(2);
    `CHK("rx dma pin", 1'b0, rx_dma_n)
    wreg(`UIF_OFS_SRC, 8'h49);
    idle(2);
    `CHK("rx dma pin", 1'b1, rx_dma_n)
    // 8-bit characters: 4*8+12 = 44 ticks before the timeout
    @(posedge clk);
    tick <= 1'b1;
    idle(38);
    rchk(`UIF_OFS_SRC, 8'hc1);
    idle(8);
    rchk(`UIF_OFS_SRC, 8'hcc);
    `CHK("rx dma pin", 1'b0, rx_dma_n)
    @(posedge clk);
    tick <= 1'b0;
    rreg(`UIF_OFS_DATA);
    idle(3);
    rchk(`UIF_OFS_SRC, 8'hc1);
    wreg(`UIF_OFS_EFR, 8'hd0);
    wreg(`UIF_OFS_MASK, 8'he0);
    ev(2);
    rchk(`UIF_OFS_SRC, 8'hd0);
    rchk(`UIF_OFS_SRC, 8'hc1);
    ev(2);
    ev(3);
    rchk(`UIF_OFS_SRC, 8'hc1);
    ev(5);
    ev(4);
    rchk(`UIF_OFS_SRC, 8'hc1);
    for (int w = 0; w < 2; w++) begin
      line_up(w[0]);
      rchk(`UIF_OFS_SRC, 8'he0);
      rreg(`UIF_OFS_MSR);
      rchk(`UIF_OFS_SRC, 8'hc1);
    end
    wreg(`UIF_OFS_MASK, 8'ha0);
    line_up(1'b1);
    rchk(`UIF_OFS_SRC, 8'hc1);
    wreg(`UIF_OFS_SRC, 8'h11);
    wreg(`UIF_OFS_MASK, 8'h02);
    idle(2);
    `CHK("irq", 1'b1, irq)
    for (int i = 0; i < 5; i++) wreg(`UIF_OFS_DATA, 8'h5a ^ 8'(i));
    idle(1);
    `CHK("tx data", 8'h5e, tx_data)
    ev(6);
    rchk(`UIF_OFS_SRC, 8'hc1);
    ev(6);
    rchk(`UIF_OFS_SRC, 8'hc2);
    `CHK("tx dma pin", 1'b1, tx_dma_n)
    wreg(`UIF_OFS_MASK, 8'h20);
    wreg(`UIF_OFS_EFR, 8'h00);
    ev(2);
    rchk(`UIF_OFS_SRC, 8'hc1);
    rx_rst_cnt = 0;
    tx_rst_cnt = 0;
    wreg(`UIF_OFS_SRC, 8'h06);
    idle(2);
    `CHK("fifo enable", 1'b0, fifo_en)
    rchk(`UIF_OFS_SRC, 8'h01);
    wreg(`UIF_OFS_SRC, 8'h07);
    idle(2);
    `CHK("rx resets", 1, rx_rst_cnt)
    `CHK("tx resets", 1, tx_rst_cnt)
    wreg(`UIF_OFS_EFR, 8'h10);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      wreg(`UIF_OFS_MASK, seed[7:0]);
      rchk(`UIF_OFS_MASK, seed[7:0]);
      rchk(seed[8] ? 3'h7 : 3'h4, 8'h00);
    end
    final_report();
  end
endmodule
